// *** hdl/adc_defs.vh ***
`ifndef ADC_DEFS_VH
`define ADC_DEFS_VH

// ----------------------------------------
// Bus geometry
// ----------------------------------------
`define ADC_AD_W 32
`define ADC_CBE_W 4
`define ADC_LANE_W 8
`define ADC_ADDR_LSB 2

// ----------------------------------------
// Reset and parking values
// ----------------------------------------
`define ADC_AD_RST 32'h0000_0000
`define ADC_CBE_RST 4'h0
`define ADC_AD_PARK 32'h0000_0000
`define ADC_CBE_PARK 4'h0
`define ADC_LOW2_ZERO 2'h0
`define ADC_OE_ON 1'b0
`define ADC_OE_OFF 1'b1

// Clocks from release to parking drive, inside the 2..5 window
`define ADC_PARK_DELAY 3
// Part of that delay spent outside the timer (release flag and output register)
`define ADC_PARK_OVERHEAD 2
`define ADC_PARK_CNT_W 3

// ----------------------------------------
// Sequencer states
// ----------------------------------------
`define ADC_ST_W 2
`define ADC_ST_IDLE 2'h0
`define ADC_ST_MADDR 2'h1
`define ADC_ST_MDATA 2'h2
`define ADC_ST_TDATA 2'h3

`endif

// *** hdl/adc_sync2.v ***
`timescale 1ns/100ps
// ----------------------------------------
// Two-stage synchroniser
// ----------------------------------------
// No reset: the strap must be seen settled while reset is still held.
module adc_sync2 #(
  parameter W = 1
) (
  input wire core_clk,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);

  reg [W-1:0] meta_r;

  always @(posedge core_clk)
  begin
    meta_r <= din;
    dout <= meta_r;
  end

endmodule // adc_sync2

// *** hdl/adc_park_timer.v ***
`timescale 1ns/100ps
// ----------------------------------------
// One-shot delay after reset release
// ----------------------------------------
module adc_park_timer #(
  parameter CNT_W = 3,
  parameter [CNT_W-1:0] LIMIT = {{(CNT_W-1){1'b0}}, 1'b1}
) (
  input wire core_clk,
  input wire resetn,
  input wire run,
  output reg done_r
);

  reg [CNT_W-1:0] cnt_r;

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_r <= {CNT_W{1'b0}};
      done_r <= 1'b0;
    end
    else if (run && !done_r)
    begin
      cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      if (cnt_r == LIMIT - {{(CNT_W-1){1'b0}}, 1'b1})
        done_r <= 1'b1;
    end
  end

endmodule // adc_park_timer

// *** hdl/adc_drive_ctl.v ***
`timescale 1ns/100ps
`include "adc_defs.vh"
// ----------------------------------------
// Address/data and command/byte-enable drive control
// ----------------------------------------
module adc_drive_ctl #(
  parameter AD_W = `ADC_AD_W,
  parameter CBE_W = `ADC_CBE_W,
  parameter PARK_DELAY = `ADC_PARK_DELAY
) (
  input wire core_clk,
  input wire resetn,
  input wire host_request_strap_n,
  input wire bridge_own_grant_n,
  input wire no_grant_active,
  input wire bus_idle,
  input wire [AD_W-1:0] ad_in,
  output reg [AD_W-1:0] ad_out,
  output reg ad_oe_n,
  input wire [CBE_W-1:0] cbe_in,
  output reg [CBE_W-1:0] cbe_out,
  output reg cbe_oe_n,
  input wire mst_start,
  input wire mst_write,
  input wire [AD_W-1:0] mst_addr,
  input wire [CBE_W-1:0] mst_cmd,
  input wire [AD_W-1:0] mst_wdata,
  input wire [CBE_W-1:0] mst_be_n,
  input wire mst_beat,
  input wire mst_last,
  output reg mst_busy,
  output reg [AD_W-1:0] mst_rdata,
  output reg mst_rdata_valid,
  input wire tgt_addr_phase,
  input wire tgt_read,
  input wire [AD_W-1:0] tgt_rdata,
  input wire tgt_beat,
  input wire tgt_last,
  output reg [AD_W-1:0] tgt_addr,
  output reg [CBE_W-1:0] tgt_cmd,
  output reg [AD_W-1:0] tgt_wdata,
  output reg [CBE_W-1:0] tgt_be_n,
  output reg tgt_wdata_valid,
  output reg arb_enabled
);

  // ----------------------------------------
  // Byte-lane mask from active-low enables
  // ----------------------------------------
  function [AD_W-1:0] lane_mask;
    input [CBE_W-1:0] be_n;
    integer i;
    begin
      lane_mask = {AD_W{1'b0}};
      for (i = 0; i < CBE_W; i = i + 1)
        lane_mask[i*`ADC_LANE_W +: `ADC_LANE_W] = {`ADC_LANE_W{~be_n[i]}};
    end
  endfunction

  // ----------------------------------------
  // Master-role state decode
  // ----------------------------------------
  function is_mst_state;
    input [`ADC_ST_W-1:0] st;
    begin
      is_mst_state = (st == `ADC_ST_MADDR) || (st == `ADC_ST_MDATA);
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Pins move off our clock, so AD, C/BE, strap and own-grant pass two flops before use; bus_idle and no_grant_active are used as they come
  wire [AD_W-1:0] ad_s;
  wire [CBE_W-1:0] cbe_s;
  wire strap_s;
  wire own_grant_n_s;

  adc_sync2 #(
    .W(AD_W)
  ) u_sync_ad (
    .core_clk(core_clk),
    .din(ad_in),
    .dout(ad_s)
  );

  adc_sync2 #(
    .W(CBE_W)
  ) u_sync_cbe (
    .core_clk(core_clk),
    .din(cbe_in),
    .dout(cbe_s)
  );

  adc_sync2 #(
    .W(2)
  ) u_sync_ctl (
    .core_clk(core_clk),
    .din({host_request_strap_n, bridge_own_grant_n}),
    .dout({strap_s, own_grant_n_s})
  );

  // ----------------------------------------
  // Release flag, strap and parking delay
  // ----------------------------------------
  reg released_r;
  wire park_ready;
  wire park_timer_done;

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      released_r <= 1'b0;
      arb_enabled <= 1'b0;
    end
    else if (!released_r)
    begin
      released_r <= 1'b1;
      // High strap enables the internal arbiter
      arb_enabled <= strap_s;
    end
  end

  // Timer covers only what the release flag and output register do not
  localparam [31:0] PARK_LIMIT_FULL = PARK_DELAY - `ADC_PARK_OVERHEAD;
  localparam [`ADC_PARK_CNT_W-1:0] PARK_LIMIT = PARK_LIMIT_FULL[`ADC_PARK_CNT_W-1:0];

  adc_park_timer #(
    .CNT_W(`ADC_PARK_CNT_W),
    .LIMIT(PARK_LIMIT)
  ) u_park_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .run(released_r),
    .done_r(park_timer_done)
  );

  // Shortest legal delay needs no timer; a zero limit would wrap the counter
  assign park_ready = (PARK_LIMIT == {`ADC_PARK_CNT_W{1'b0}}) ? released_r : park_timer_done;

  // ----------------------------------------
  // Phase sequencer
  // ----------------------------------------
  reg [`ADC_ST_W-1:0] state_r;
  reg [`ADC_ST_W-1:0] state_nxt;
  reg mst_write_r;
  reg tgt_read_r;
  reg [AD_W-1:0] mst_addr_r;
  reg [CBE_W-1:0] mst_cmd_r;

  wire own_idle = !own_grant_n_s && bus_idle;
  // Parking needs the arbiter on; with it off this term is dead
  wire park_now = arb_enabled && park_ready && no_grant_active && bus_idle;
  wire mst_go = released_r && mst_start && own_idle;
  // A target hit loses to our own master start in the same clock
  wire tgt_go = released_r && tgt_addr_phase && !mst_go;

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      `ADC_ST_IDLE:
      begin
        if (mst_go)
          state_nxt = `ADC_ST_MADDR;
        else if (tgt_go)
          state_nxt = `ADC_ST_TDATA;
      end
      // Exactly one address clock, then data until the last beat
      `ADC_ST_MADDR:
        state_nxt = `ADC_ST_MDATA;
      `ADC_ST_MDATA:
      begin
        if (mst_beat && mst_last)
          state_nxt = `ADC_ST_IDLE;
      end
      `ADC_ST_TDATA:
      begin
        if (tgt_beat && tgt_last)
          state_nxt = `ADC_ST_IDLE;
      end
      default:
        state_nxt = `ADC_ST_IDLE;
    endcase
  end

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= `ADC_ST_IDLE;
      mst_write_r <= 1'b0;
      tgt_read_r <= 1'b0;
      mst_addr_r <= `ADC_AD_RST;
      mst_cmd_r <= `ADC_CBE_RST;
    end
    else
    begin
      state_r <= state_nxt;
      if (mst_go && state_r == `ADC_ST_IDLE)
      begin
        mst_write_r <= mst_write;
        mst_addr_r <= mst_addr;
        mst_cmd_r <= mst_cmd;
      end
      if (tgt_go && state_r == `ADC_ST_IDLE)
        tgt_read_r <= tgt_read;
    end
  end

  // ----------------------------------------
  // Pin drive, next values
  // ----------------------------------------
  reg [AD_W-1:0] ad_nxt;
  reg ad_oe_n_nxt;
  reg [CBE_W-1:0] cbe_nxt;
  reg cbe_oe_n_nxt;

  always @*
  begin
    // Released by default once out of reset
    ad_nxt = `ADC_AD_PARK;
    ad_oe_n_nxt = `ADC_OE_OFF;
    cbe_nxt = `ADC_CBE_PARK;
    cbe_oe_n_nxt = `ADC_OE_OFF;
    case (state_nxt)
      `ADC_ST_MADDR:
      begin
        ad_nxt = {mst_addr[AD_W-1:`ADC_ADDR_LSB], `ADC_LOW2_ZERO};
        ad_oe_n_nxt = `ADC_OE_ON;
        cbe_nxt = mst_cmd;
        cbe_oe_n_nxt = `ADC_OE_ON;
      end
      `ADC_ST_MDATA:
      begin
        // Reads release the lanes so the target can drive them
        ad_nxt = mst_write_r ? mst_wdata : `ADC_AD_PARK;
        ad_oe_n_nxt = mst_write_r ? `ADC_OE_ON : `ADC_OE_OFF;
        cbe_nxt = mst_be_n;
        cbe_oe_n_nxt = `ADC_OE_ON;
      end
      `ADC_ST_TDATA:
      begin
        // Command lines stay released as target
        ad_nxt = tgt_rdata;
        ad_oe_n_nxt = (state_r == `ADC_ST_TDATA ? tgt_read_r : tgt_read) ? `ADC_OE_ON : `ADC_OE_OFF;
        cbe_oe_n_nxt = `ADC_OE_OFF;
      end
      default:
      begin
        if (released_r && (park_now || own_idle))
        begin
          ad_oe_n_nxt = `ADC_OE_ON;
          cbe_oe_n_nxt = `ADC_OE_ON;
        end
      end
    endcase
  end

  // Leading edge of reset forces low drive at once; first clock after the trailing edge releases
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ad_out <= `ADC_AD_RST;
      ad_oe_n <= `ADC_OE_ON;
      cbe_out <= `ADC_CBE_RST;
      cbe_oe_n <= `ADC_OE_ON;
    end
    else
    begin
      ad_out <= ad_nxt;
      ad_oe_n <= ad_oe_n_nxt;
      cbe_out <= cbe_nxt;
      cbe_oe_n <= cbe_oe_n_nxt;
    end
  end

  // ----------------------------------------
  // Master status and read capture
  // ----------------------------------------
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mst_busy <= 1'b0;
      mst_rdata <= `ADC_AD_RST;
      mst_rdata_valid <= 1'b0;
    end
    else
    begin
      // Busy follows the next state so it lines up with the pins
      mst_busy <= is_mst_state(state_nxt);
      mst_rdata_valid <= 1'b0;
      if (state_r == `ADC_ST_MDATA && mst_beat && !mst_write_r)
      begin
        // Pins reach ad_s two clocks late, so read data must stand that long first
        // Disabled lanes read as zero
        mst_rdata <= ad_s & lane_mask(cbe_out);
        mst_rdata_valid <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Target address and write capture
  // ----------------------------------------
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tgt_addr <= `ADC_AD_RST;
      tgt_cmd <= `ADC_CBE_RST;
      tgt_wdata <= `ADC_AD_RST;
      tgt_be_n <= `ADC_CBE_RST;
      tgt_wdata_valid <= 1'b0;
    end
    else
    begin
      tgt_wdata_valid <= 1'b0;
      if (state_r == `ADC_ST_IDLE && state_nxt == `ADC_ST_TDATA)
      begin
        // Address phase: lines are inputs, command observed only
        tgt_addr <= ad_s;
        tgt_cmd <= cbe_s;
      end
      if (state_r == `ADC_ST_TDATA && tgt_beat && !tgt_read_r)
      begin
        // Little-endian lanes kept in place, disabled lanes zeroed
        tgt_wdata <= ad_s & lane_mask(cbe_s);
        tgt_be_n <= cbe_s;
        tgt_wdata_valid <= 1'b1;
      end
    end
  end

endmodule // adc_drive_ctl

// *** dv/adc_drive_ctl_monitor.sv ***
`timescale 1ns/100ps
// ----------
// Drive checker
// ----------
module adc_drive_mon (
  input wire core_clk,
  input wire resetn,
  input wire host_request_strap_n,
  input wire bridge_own_grant_n,
  input wire no_grant_active,
  input wire bus_idle,
  input wire [31:0] ad_out,
  input wire ad_oe_n,
  input wire [3:0] cbe_out,
  input wire cbe_oe_n,
  input wire mst_start,
  input wire mst_write,
  input wire [31:0] mst_addr,
  input wire [3:0] mst_cmd,
  input wire [31:0] mst_wdata,
  input wire [3:0] mst_be_n,
  input wire mst_busy,
  input wire tgt_addr_phase,
  input wire arb_enabled
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // No transfer running or about to start
  wire calm = bus_idle && !mst_busy && !mst_start && !tgt_addr_phase;
  chk_rst_low: assert property ($rose(resetn) |-> !ad_oe_n && !cbe_oe_n && !ad_out && !cbe_out)
    else $error("lines not low in reset");
  chk_rst_release: assert property ($rose(resetn) |=> ad_oe_n && cbe_oe_n)
    else $error("lines not released");
  chk_strap_cap: assert property ($rose(resetn) |=> arb_enabled == $past(host_request_strap_n))
    else $error("strap not captured");
  chk_arb_park: assert property ((arb_enabled && no_grant_active && calm)[*2] |=> !ad_oe_n && !cbe_oe_n && !ad_out)
    else $error("idle bus not parked");
  chk_no_park: assert property ((!arb_enabled && bridge_own_grant_n && !mst_busy)[*4] |-> cbe_oe_n)
    else $error("parked with arbiter off");
  chk_own_grant: assert property ((!bridge_own_grant_n && calm)[*4] |=> !ad_oe_n && !ad_out)
    else $error("granted idle bus not driven");
  chk_mst_addr: assert property ($rose(mst_busy) |-> !ad_oe_n && !cbe_oe_n && cbe_out == $past(mst_cmd)
    && ad_out == ($past(mst_addr) & 32'hffff_fffc))
    else $error("bad address phase");
  chk_mst_wdata: assert property (mst_busy && $past(mst_busy) && mst_write |-> !ad_oe_n
    && ad_out == $past(mst_wdata) && cbe_out == $past(mst_be_n))
    else $error("bad write data phase");
  chk_mst_read: assert property (mst_busy && $past(mst_busy) && !mst_write |-> ad_oe_n && !cbe_oe_n)
    else $error("bad read data phase");
  cov_wr: cover property ($rose(mst_busy) && mst_write);
  cov_rd: cover property ($rose(mst_busy) && !mst_write);
  cov_park: cover property ($fell(ad_oe_n) && arb_enabled && !mst_busy);
endmodule // adc_drive_mon

bind adc_drive_ctl adc_drive_mon u_mon (
  .core_clk(core_clk),
  .resetn(resetn),
  .host_request_strap_n(host_request_strap_n),
  .bridge_own_grant_n(bridge_own_grant_n),
  .no_grant_active(no_grant_active),
  .bus_idle(bus_idle),
  .ad_out(ad_out),
  .ad_oe_n(ad_oe_n),
  .cbe_out(cbe_out),
  .cbe_oe_n(cbe_oe_n),
  .mst_start(mst_start),
  .mst_write(mst_write),
  .mst_addr(mst_addr),
  .mst_cmd(mst_cmd),
  .mst_wdata(mst_wdata),
  .mst_be_n(mst_be_n),
  .mst_busy(mst_busy),
  .tgt_addr_phase(tgt_addr_phase),
  .arb_enabled(arb_enabled)
);

// *** dv/adc_bus_agent.sv ***
`timescale 1ns/100ps
// ----------
// Far-side agent and pin levels
// ----------
module adc_bus_agent (
  input wire core_clk,
  input wire [31:0] ad_out,
  input wire ad_oe_n,
  input wire [3:0] cbe_out,
  input wire cbe_oe_n,
  input wire drv_en,
  input wire [31:0] drv_ad,
  input wire [3:0] drv_cbe,
  output wire [31:0] ad_wire,
  output wire [3:0] cbe_wire
);
  reg [31:0] ad_last_r = 32'h0;
  reg [3:0] cbe_last_r = 4'h0;
  // Floating lines flip every cycle so stale data never looks fresh
  always @(posedge core_clk)
  begin
    ad_last_r <= ad_wire;
    cbe_last_r <= cbe_wire;
  end
  // Agent only drives what the bridge has released, so no contention
  assign ad_wire = !ad_oe_n ? ad_out : drv_en ? drv_ad : ~ad_last_r;
  assign cbe_wire = !cbe_oe_n ? cbe_out : drv_en ? drv_cbe : ~cbe_last_r;
endmodule // adc_bus_agent

// *** dv/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  logic core_clk = 1'b0, resetn = 1'b0, host_request_strap_n = 1'b1;
  logic bridge_own_grant_n = 1'b1, no_grant_active = 1'b1, bus_idle = 1'b1;
  logic mst_start = 1'b0, mst_write = 1'b0, mst_beat = 1'b0, mst_last = 1'b0, drv_en = 1'b0;
  logic tgt_addr_phase = 1'b0, tgt_read = 1'b0, tgt_beat = 1'b0, tgt_last = 1'b0;
  logic [31:0] mst_addr = 32'h0, mst_wdata = 32'h0, tgt_rdata = 32'h0, drv_ad = 32'h0;
  logic [3:0] mst_cmd = 4'h0, mst_be_n = 4'h0, drv_cbe = 4'h0;
  wire [31:0] ad_out, ad_wire, mst_rdata, tgt_addr, tgt_wdata;
  wire [3:0] cbe_out, cbe_wire, tgt_cmd, tgt_be_n;
  wire ad_oe_n, cbe_oe_n, mst_busy, mst_rdata_valid, tgt_wdata_valid, arb_enabled;
  integer seed = 32'h262ce037;
  integer failures = 0, checks = 0, i, k, n;

  adc_drive_ctl dut (.ad_in(ad_wire), .cbe_in(cbe_wire), .*);
  adc_bus_agent agent (.*);

  always #25 core_clk = ~core_clk;

  // ----------
  // Helpers
  // ----------
  task tick;
    @(posedge core_clk);
    #5;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("CHECK FAILED at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  task report_and_stop;
    if (failures == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic [31:0] lanes(input [31:0] d, input [3:0] be_n);
    integer j;
    lanes = 32'h0;
    for (j = 0; j < 4; j = j + 1)
      if (!be_n[j])
        lanes[8*j +: 8] = d[8*j +: 8];
  endfunction

  task do_reset(input logic strap);
    resetn = 1'b0;
    host_request_strap_n = strap;
    repeat (12) tick;
    check(ad_out, 32'h0);
    check({ad_oe_n, cbe_oe_n, cbe_out}, 32'h0);
    resetn = 1'b1;
  endtask

  task master(input logic wr, input integer beats);
    mst_addr = $random(seed);
    mst_cmd = 4'($random(seed));
    mst_be_n = 4'($random(seed));
    drv_ad = $random(seed);
    mst_write = wr;
    drv_en = !wr;
    mst_start = 1'b1;
    tick;
    mst_start = 1'b0;
    check(ad_out, {mst_addr[31:2], 2'h0});
    check(cbe_out, mst_cmd);
    for (i = 0; i < beats; i = i + 1)
    begin
      mst_wdata = $random(seed);
      mst_be_n = wr ? 4'($random(seed)) : mst_be_n;
      tick;
      check(wr ? ad_out : {31'h0, ad_oe_n}, wr ? mst_wdata : 32'h1);
      check(cbe_out, mst_be_n);
      if (!wr)
        repeat (2) tick;
      mst_beat = 1'b1;
      mst_last = (i == beats - 1);
    end
    tick;
    mst_beat = 1'b0;
    mst_last = 1'b0;
    for (k = 0; !wr && mst_rdata_valid !== 1'b1 && k < 6; k = k + 1)
      tick;
    check(mst_rdata_valid, !wr);
    if (!wr)
      check(mst_rdata, lanes(drv_ad, mst_be_n));
    drv_en = 1'b0;
    for (k = 0; mst_busy !== 1'b0 && k < 6; k = k + 1)
      tick;
    check(mst_busy, 1'b0);
    tick;
  endtask

  task target(input logic rd);
    drv_ad = $random(seed);
    drv_cbe = 4'($random(seed));
    drv_en = 1'b1;
    repeat (3) tick;
    tgt_addr_phase = 1'b1;
    tgt_read = rd;
    tgt_rdata = $random(seed);
    tick;
    tgt_addr_phase = 1'b0;
    repeat (3) tick;
    check(tgt_addr, drv_ad);
    check(tgt_cmd, drv_cbe);
    drv_en = !rd;
    drv_ad = $random(seed);
    drv_cbe = 4'($random(seed));
    repeat (3) tick;
    check(cbe_oe_n, 1'b1);
    if (rd)
      check(ad_out, tgt_rdata);
    check(ad_oe_n, !rd);
    tgt_beat = 1'b1;
    tgt_last = 1'b1;
    tick;
    tgt_beat = 1'b0;
    tgt_last = 1'b0;
    for (k = 0; !rd && tgt_wdata_valid !== 1'b1 && k < 6; k = k + 1)
      tick;
    check(tgt_wdata_valid, !rd);
    if (!rd)
      check(tgt_wdata, lanes(drv_ad, drv_cbe));
    if (!rd)
      check(tgt_be_n, drv_cbe);
    drv_en = 1'b0;
    repeat (3) tick;
    check(ad_oe_n, 1'b1);
  endtask

  // ----------
  // Sequence
  // ----------
  initial
  begin
    do_reset(1'b1);
    repeat (2) tick;
    check(ad_oe_n, 1'b1);
    repeat (3) tick;
    check({ad_oe_n, cbe_oe_n, arb_enabled}, 3'h1);
    bus_idle = 1'b0;
    tick;
    check(ad_oe_n, 1'b1);
    bus_idle = 1'b1;
    no_grant_active = 1'b0;
    repeat (2) tick;
    check(ad_oe_n, 1'b1);
    bridge_own_grant_n = 1'b0;
    repeat (4) tick;
    check(ad_oe_n, 1'b0);
    for (n = 0; n < 14; n = n + 1)
    begin
      k = $random(seed);
      master(k[0], k[0] ? 1 + k[2:1] : 1);
    end
    bridge_own_grant_n = 1'b1;
    no_grant_active = 1'b1;
    do_reset(1'b0);
    repeat (6) tick;
    check({arb_enabled, ad_oe_n, cbe_oe_n}, 3'h3);
    target(1'b0);
    target(1'b1);
    bridge_own_grant_n = 1'b0;
    repeat (4) tick;
    master(1'b1, 2);
    bridge_own_grant_n = 1'b1;
    repeat (4) tick;
    check(ad_oe_n, 1'b1);
    report_and_stop;
  end

  // Run needs well under a thousand cycles; this allows twenty thousand
  initial
  begin
    #1000000;
    failures = failures + 1;
    report_and_stop;
  end
endmodule // tb_top
